//--- lrc_pkg.sv
`default_nettype none

package lrc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] LINREG_A_CONTROL_OFFSET = 8'h08;
    localparam logic [7:0] LINREG_B_CONTROL_OFFSET = 8'h09;
    localparam logic [7:0] LINREG_A_VOLTAGE_OFFSET = 8'h0a;
    localparam logic [7:0] LINREG_B_VOLTAGE_OFFSET = 8'h0b;
    localparam logic [7:0] CONV_A_SEQ_DELAY_OFFSET = 8'h0c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT     = 0;
    localparam int CTRL_PIN_GATING_BIT = 1;
    localparam int CTRL_DISCHARGE_BIT  = 2;
    localparam int VOLTAGE_CODE_MSB    = 4;
    localparam int VOLTAGE_CODE_WIDTH  = 5;
    localparam int DELAY_ON_LSB        = 0;
    localparam int DELAY_OFF_LSB       = 4;
    localparam int DELAY_FIELD_WIDTH   = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET      = 8'h07;
    localparam logic [7:0] VOLTAGE_RESET      = 8'h19;
    localparam logic [3:0] DELAY_OFF_RESET    = 4'h2;
    localparam logic [7:0] UNMAPPED_READ_DATA = 8'h00;

    // ------------------------------------------------------------
    // Voltage decode: base and step in millivolts
    // ------------------------------------------------------------
    localparam logic [11:0] VOLTAGE_BASE_MV = 12'h320;
    localparam logic [11:0] VOLTAGE_STEP_MV = 12'h064;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lrc_req_type;

    typedef struct packed {
        logic                          enable;
        logic                          pin_gating;
        logic                          discharge_enable;
        logic [VOLTAGE_CODE_WIDTH-1:0] voltage_code;
    } lrc_chan_cfg_type;

    // Linear code to millivolts
    function automatic logic [11:0] lrc_code_to_mv(input logic [4:0] code);
        logic [11:0] product;
        product = 12'({7'h00, code}) * VOLTAGE_STEP_MV;
        return VOLTAGE_BASE_MV + product;
    endfunction : lrc_code_to_mv

    // Build a channel's settings from its two registers
    function automatic lrc_chan_cfg_type lrc_cfg(input logic [7:0] ctrl,
                                                 input logic [7:0] volt);
        lrc_chan_cfg_type c;
        c.enable           = ctrl[CTRL_ENABLE_BIT];
        c.pin_gating       = ctrl[CTRL_PIN_GATING_BIT];
        c.discharge_enable = ctrl[CTRL_DISCHARGE_BIT];
        c.voltage_code     = volt[VOLTAGE_CODE_MSB:0];
        return c;
    endfunction : lrc_cfg

endpackage : lrc_pkg

`default_nettype wire

//--- lrc_channel.sv
`default_nettype none

module lrc_channel
(
    input  wire logic                      clk_i,       // System clock
    input  wire logic                      resetn_i,    // Async reset, active low
    input  wire lrc_pkg::lrc_chan_cfg_type cfg_i,       // Register settings
    input  wire logic                      pin_level_i, // Synchronised enable pin
    output logic                           reg_on_o,    // Regulator runs
    output logic                           discharge_o, // Discharge resistor connected
    output logic [11:0]                    vout_mv_o    // Target output in mV
);

    import lrc_pkg::*;

    logic next_on;

    // ------------------------------------------------------------
    // Enable decision
    // ------------------------------------------------------------
    // Pin gates the enable bit only when gating is selected
    always_comb begin
        next_on = cfg_i.enable && (!cfg_i.pin_gating || pin_level_i); // RQ2 RQ3
    end

    // Regulator on/off
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_on_o <= 1'b0;
        end else begin
            reg_on_o <= next_on; // RQ3
        end
    end

    // Discharge only while off and only if allowed
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            discharge_o <= 1'b0;
        end else begin
            discharge_o <= !next_on && cfg_i.discharge_enable; // RQ1
        end
    end

    // ------------------------------------------------------------
    // Voltage decode
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            vout_mv_o <= 12'h000;
        end else begin
            vout_mv_o <= lrc_code_to_mv(cfg_i.voltage_code); // RQ4
        end
    end

endmodule : lrc_channel

`default_nettype wire

//--- lrc_regs.sv
// Notes on behaviour
// RQ1: A regulator's discharge resistor is connected while it is off only if its bit 2 is set.
// RQ2: With bit 1 clear the enable bit alone switches the regulator; set, the enable pin must also be high.
// RQ3: Bit 0 of a control register turns its regulator off (0) or on (1), subject to pin gating.
// RQ4: The 5-bit voltage code maps linearly from 0x00 at 0.8 V in 100 mV steps to 0x19 at 3.3 V.
// RQ5: The host never writes voltage codes 0x1A to 0x1F, which are reserved.
// RQ6: After reset both voltage fields hold code 0x19, the 3.3 V setting.
// RQ7: Reserved bits reset to zero and the host keeps them at zero when writing.
// RQ8: After reset both control registers read 0x07, with enable, gating and discharge set.
`default_nettype none

module lrc_regs
#(
    parameter logic [3:0] DELAY_ON_RESET = 4'h0  // Start-up delay field reset
)(
    input  wire logic                 clk_i,              // System clock, 100 MHz
    input  wire logic                 resetn_i,           // Async reset, active low
    input  wire lrc_pkg::lrc_req_type req_i,              // Register read/write request
    input  wire logic                 en_pin_i,           // External enable pin
    output logic [7:0]                rdata_o,            // Read data
    output logic                      rvalid_o,           // Read data valid pulse
    output logic                      a_on_o,             // Regulator A runs
    output logic                      a_discharge_o,      // Regulator A discharge on
    output logic [11:0]               a_vout_mv_o,        // Regulator A target mV
    output logic                      b_on_o,             // Regulator B runs
    output logic                      b_discharge_o,      // Regulator B discharge on
    output logic [11:0]               b_vout_mv_o,        // Regulator B target mV
    output logic [3:0]                conv_a_on_delay_o,  // Converter A start-up delay code
    output logic [3:0]                conv_a_off_delay_o  // Converter A shutdown delay code
);

    import lrc_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] linreg_a_control;
    logic [7:0] linreg_b_control;
    logic [7:0] linreg_a_voltage;
    logic [7:0] linreg_b_voltage;
    logic [7:0] converter_a_sequence_delay;
    logic [2:0] pin_sync;
    logic       pin_level;
    logic [7:0] next_rdata;

    // ------------------------------------------------------------
    // Enable pin synchroniser
    // ------------------------------------------------------------
    // Three stages; level follows once stages two and three agree
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_sync <= 3'h0;
        end else begin
            pin_sync <= {pin_sync[1:0], en_pin_i};
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_level <= 1'b0;
        end else if (pin_sync[1] == pin_sync[2]) begin
            pin_level <= pin_sync[2]; // RQ2
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Control registers; all eight bits stored, reserved bits reset zero
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            linreg_a_control <= CONTROL_RESET; // RQ8 RQ7
            linreg_b_control <= CONTROL_RESET; // RQ8 RQ7
        end else if (req_i.write) begin
            if (req_i.addr == LINREG_A_CONTROL_OFFSET) begin
                linreg_a_control <= req_i.wdata;
            end
            if (req_i.addr == LINREG_B_CONTROL_OFFSET) begin
                linreg_b_control <= req_i.wdata;
            end
        end
    end

    // Voltage registers; reserved codes stored as written
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            linreg_a_voltage <= VOLTAGE_RESET; // RQ6 RQ7
            linreg_b_voltage <= VOLTAGE_RESET; // RQ6 RQ7
        end else if (req_i.write) begin
            if (req_i.addr == LINREG_A_VOLTAGE_OFFSET) begin
                linreg_a_voltage <= req_i.wdata;
            end
            if (req_i.addr == LINREG_B_VOLTAGE_OFFSET) begin
                linreg_b_voltage <= req_i.wdata;
            end
        end
    end

    // Converter A sequencing delay layout
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            converter_a_sequence_delay <= {DELAY_OFF_RESET, DELAY_ON_RESET};
        end else if (req_i.write && req_i.addr == CONV_A_SEQ_DELAY_OFFSET) begin
            converter_a_sequence_delay <= req_i.wdata;
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    // Address decode; unmapped reads return zero
    always_comb begin
        case (req_i.addr)
            LINREG_A_CONTROL_OFFSET: next_rdata = linreg_a_control;
            LINREG_B_CONTROL_OFFSET: next_rdata = linreg_b_control;
            LINREG_A_VOLTAGE_OFFSET: next_rdata = linreg_a_voltage;
            LINREG_B_VOLTAGE_OFFSET: next_rdata = linreg_b_voltage;
            CONV_A_SEQ_DELAY_OFFSET: next_rdata = converter_a_sequence_delay;
            default:                 next_rdata = UNMAPPED_READ_DATA;
        endcase
    end

    // Registered read answer, one cycle after the request
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o  <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= req_i.read;
            if (req_i.read) begin
                rdata_o <= next_rdata;
            end
        end
    end

    // Delay fields out to the sequencer
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            conv_a_on_delay_o  <= 4'h0;
            conv_a_off_delay_o <= 4'h0;
        end else begin
            conv_a_on_delay_o  <= converter_a_sequence_delay[DELAY_ON_LSB +: DELAY_FIELD_WIDTH];
            conv_a_off_delay_o <= converter_a_sequence_delay[DELAY_OFF_LSB +: DELAY_FIELD_WIDTH];
        end
    end

    // ------------------------------------------------------------
    // Regulator channels
    // ------------------------------------------------------------
    lrc_channel u_linreg_a (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .cfg_i       (lrc_cfg(linreg_a_control, linreg_a_voltage)),
        .pin_level_i (pin_level),
        .reg_on_o    (a_on_o),
        .discharge_o (a_discharge_o),
        .vout_mv_o   (a_vout_mv_o)
    );

    lrc_channel u_linreg_b (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .cfg_i       (lrc_cfg(linreg_b_control, linreg_b_voltage)),
        .pin_level_i (pin_level),
        .reg_on_o    (b_on_o),
        .discharge_o (b_discharge_o),
        .vout_mv_o   (b_vout_mv_o)
    );

endmodule : lrc_regs

`default_nettype wire

//--- lrc_regs_monitor.sv
`default_nettype none

module lrc_regs_monitor
(
    input  wire logic                 clk_i,         // System clock
    input  wire logic                 resetn_i,      // Async reset, active low
    input  wire lrc_pkg::lrc_req_type req_i,         // Register request
    input  wire logic                 a_on_o,        // Regulator A runs
    input  wire logic                 a_discharge_o, // Regulator A discharge
    input  wire logic [11:0]          a_vout_mv_o,   // Regulator A target mV
    input  wire logic                 b_on_o,        // Regulator B runs
    input  wire logic                 b_discharge_o, // Regulator B discharge
    input  wire logic [11:0]          b_vout_mv_o    // Regulator B target mV
);
    import lrc_pkg::*;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking mon_cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    chk_a_discharge_on : assert property (
        (req_i.write && req_i.addr == LINREG_A_CONTROL_OFFSET && req_i.wdata[2:0] == 3'h4)
        |-> ##[1:2] (a_discharge_o && !a_on_o)) else $error("A discharge not on");
    chk_b_discharge_off : assert property (
        (req_i.write && req_i.addr == LINREG_B_CONTROL_OFFSET && !req_i.wdata[2])
        |-> ##[1:2] !b_discharge_o) else $error("B discharge not off");
    chk_discharge_exclusive : assert property (
        a_on_o |-> !a_discharge_o) else $error("A discharge while on");
    chk_enable_off : assert property (
        (req_i.write && req_i.addr == LINREG_A_CONTROL_OFFSET && !req_i.wdata[0])
        |-> ##[1:2] !a_on_o) else $error("A still on");
    chk_ungated_on : assert property (
        (req_i.write && req_i.addr == LINREG_B_CONTROL_OFFSET && req_i.wdata[1:0] == 2'h1)
        |-> ##[1:2] b_on_o) else $error("B not on");
    chk_vout_decode : assert property (
        (req_i.write && req_i.addr == LINREG_A_VOLTAGE_OFFSET) |-> ##2
        a_vout_mv_o == 12'h320 + 12'h064 * 12'($past(req_i.wdata, 2) & 8'h1f))
        else $error("A voltage decode wrong");
    chk_reset_vout : assert property (
        $rose(resetn_i) |-> ##[0:1] (a_vout_mv_o == 12'hce4 && b_vout_mv_o == 12'hce4))
        else $error("Reset voltage wrong");
    chk_reset_discharge : assert property (
        $rose(resetn_i) |-> ##[0:1] (a_discharge_o && b_discharge_o))
        else $error("Reset discharge wrong");
endmodule : lrc_regs_monitor

bind lrc_regs lrc_regs_monitor lrc_regs_monitor_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i),
    .a_on_o(a_on_o), .a_discharge_o(a_discharge_o), .a_vout_mv_o(a_vout_mv_o),
    .b_on_o(b_on_o), .b_discharge_o(b_discharge_o), .b_vout_mv_o(b_vout_mv_o)
);

`default_nettype wire

//--- testbench.sv
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import lrc_pkg::*;

    logic        clk_i, resetn_i, en_pin_i, rvalid_o;
    lrc_req_type req_i;
    logic [7:0]  rdata_o;
    logic        a_on_o, a_discharge_o, b_on_o, b_discharge_o;
    logic [11:0] a_vout_mv_o, b_vout_mv_o;
    logic [3:0]  conv_a_on_delay_o, conv_a_off_delay_o;
    int          err_count, cmp_count, cyc;

    lrc_regs lrc_regs_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i), .en_pin_i(en_pin_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .a_on_o(a_on_o),
        .a_discharge_o(a_discharge_o), .a_vout_mv_o(a_vout_mv_o), .b_on_o(b_on_o),
        .b_discharge_o(b_discharge_o), .b_vout_mv_o(b_vout_mv_o),
        .conv_a_on_delay_o(conv_a_on_delay_o), .conv_a_off_delay_o(conv_a_off_delay_o)
    );

    // ------------------------------------------------------------
    // Clock and timeout
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic cmp(input string n, input logic [11:0] e, input logic [11:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    // Write, then let outputs settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req_i <= '{1'b1, 1'b0, a, d};
        @(posedge clk_i);
        req_i <= '0;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : wr
    // Read with answer one cycle later
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        req_i <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_i);
        req_i <= '0;
        #1;
        cmp("rvalid", 12'h001, 12'(rvalid_o));
        cmp("rdata", 12'(e), 12'(rdata_o));
    endtask : rd
    task automatic pin(input logic v);
        @(posedge clk_i);
        en_pin_i <= v;
        repeat (6) @(posedge clk_i);
        #1;
    endtask : pin
    task automatic give_verdict();
        $display("COUNTS compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        req_i = '0;
        en_pin_i = 1'b0;
        resetn_i = 1'b0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        rd(LINREG_A_CONTROL_OFFSET, 8'h07);
        rd(LINREG_B_CONTROL_OFFSET, 8'h07);
        rd(LINREG_A_VOLTAGE_OFFSET, 8'h19);
        rd(LINREG_B_VOLTAGE_OFFSET, 8'h19);
        cmp("a_vout", 12'hce4, a_vout_mv_o);
        cmp("b_vout", 12'hce4, b_vout_mv_o);
        cmp("a_dis", 12'h001, 12'(a_discharge_o));
        cmp("a_on", 12'h000, 12'(a_on_o));
        $display("TEST reset done");
        pin(1'b1);
        cmp("a_on", 12'h001, 12'(a_on_o));
        cmp("b_dis", 12'h000, 12'(b_discharge_o));
        wr(LINREG_A_CONTROL_OFFSET, 8'h06);
        cmp("a_on", 12'h000, 12'(a_on_o));
        cmp("a_dis", 12'h001, 12'(a_discharge_o));
        wr(LINREG_A_CONTROL_OFFSET, 8'h02);
        cmp("a_dis", 12'h000, 12'(a_discharge_o));
        wr(LINREG_A_CONTROL_OFFSET, 8'h04);
        cmp("a_dis", 12'h001, 12'(a_discharge_o));
        cmp("a_on", 12'h000, 12'(a_on_o));
        pin(1'b0);
        cmp("b_on", 12'h000, 12'(b_on_o));
        wr(LINREG_B_CONTROL_OFFSET, 8'h01);
        cmp("b_on", 12'h001, 12'(b_on_o));
        wr(LINREG_B_CONTROL_OFFSET, 8'h00);
        cmp("b_dis", 12'h000, 12'(b_discharge_o));
        $display("TEST enable done");
        for (int c = 0; c <= 25; c++) begin
            wr(LINREG_A_VOLTAGE_OFFSET, 8'(c));
            wr(LINREG_B_VOLTAGE_OFFSET, 8'(25 - c));
            cmp("a_vout", 12'(12'h320 + 12'h064 * c), a_vout_mv_o);
            cmp("b_vout", 12'(12'h320 + 12'h064 * (25 - c)), b_vout_mv_o);
            rd(LINREG_A_VOLTAGE_OFFSET, 8'(c));
        end
        rd(8'h20, 8'h00);
        $display("TEST voltage done");
        wr(CONV_A_SEQ_DELAY_OFFSET, 8'h5a);
        rd(CONV_A_SEQ_DELAY_OFFSET, 8'h5a);
        cmp("on_dly", 12'h00a, 12'(conv_a_on_delay_o));
        cmp("off_dly", 12'h005, 12'(conv_a_off_delay_o));
        $display("TEST delay done");
        // Second reset in mid-run; A control, B voltage and delay registers read back their reset values
        @(posedge clk_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        rd(LINREG_A_CONTROL_OFFSET, CONTROL_RESET);
        rd(LINREG_B_VOLTAGE_OFFSET, VOLTAGE_RESET);
        rd(CONV_A_SEQ_DELAY_OFFSET, {DELAY_OFF_RESET, 4'h0});
        cmp("b_vout", 12'hce4, b_vout_mv_o);
        cmp("b_dis", 12'h001, 12'(b_discharge_o));
        cmp("on_dly", 12'h000, 12'(conv_a_on_delay_o));
        cmp("off_dly", 12'(DELAY_OFF_RESET), 12'(conv_a_off_delay_o));
        $display("TEST reset again done");
        give_verdict();
    end
endmodule : testbench

`default_nettype wire
